// ---- tglm_bank_sva.sv ----
// Port-level checker for the tone bank
`timescale 1ns/10ps
`default_nettype none
`include "tglm_map.vh"
module tglm_bank_sva #(
  parameter integer SAMPLE_DIV = 16
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        handshake_done_i,
  input wire logic [6:0]  negotiated_mode_i,
  input wire logic [15:0] tone_sample_o,
  input wire logic        sample_strobe_o
);
  logic [6:0]  lm_reg;    // Last legal code seen
  logic [15:0] gap_reg;   // Clocks since last strobe
  logic        seen_reg;  // First strobe passed, gap is meaningful
  logic        legal;     // Code belongs to the documented set
  // Legal link codes
  always_comb begin
    case (negotiated_mode_i)
      `TGLM_LM_V22BIS_2400, `TGLM_LM_V22_1200, `TGLM_LM_B212A_1200, `TGLM_LM_V21_300,
      `TGLM_LM_B103_300, `TGLM_LM_V23_TX1200, `TGLM_LM_V23_TX75, `TGLM_LM_V29_9600,
      `TGLM_LM_V29_7200: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end
  // Reference link mode and strobe spacing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lm_reg   <= 7'h00;
      gap_reg  <= 16'h0000;
      seen_reg <= 1'b0;
    end else begin
      if (handshake_done_i && legal) lm_reg <= negotiated_mode_i;
      gap_reg <= sample_strobe_o ? 16'h0001 : gap_reg + 16'h0001;
      if (sample_strobe_o) seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_once: assert property (s_take |=> s_ack_once)
    else $error("ack not a single pulse after a taken request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_link_read: assert property (wb_ack_o && $past(!wb_we_i &&
    wb_adr_i[10:2] == `TGLM_IDX_LINK_MODE) |-> wb_dat_o == {25'h0, $past(lm_reg)})
    else $error("link mode read differs from last legal code");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_dat_hold: assert property (!$past(wb_cyc_i && wb_stb_i && !wb_we_i)
    |-> $stable(wb_dat_o)) else $error("read data moved without a read");
  a_strobe_pulse: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("sample strobe longer than one cycle");
  a_strobe_period: assert property (sample_strobe_o && seen_reg
    |-> gap_reg == SAMPLE_DIV) else $error("sample strobe spacing wrong");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !sample_strobe_o && tone_sample_o == 16'h0000)
    else $error("outputs active under reset");
endmodule // tglm_bank_sva
`default_nettype wire

// ---- tglm_host_model.sv ----
// Classic Wishbone master standing in for the host processor
`timescale 1ns/10ps
`default_nettype none
module tglm_host_model (
  input  wire logic        clk_i,  // Bus clock
  input  wire logic        ack_i,  // Slave acknowledge
  input  wire logic [31:0] dat_i,  // Read data
  output var  logic        cyc_o,  // Cycle
  output var  logic        stb_o,  // Strobe
  output var  logic        we_o,   // Write enable
  output var  logic [31:0] adr_o,  // Byte address
  output var  logic [3:0]  sel_o,  // Lanes
  output var  logic [31:0] dat_o,  // Write data
  output var  logic        hung_o  // A cycle went unanswered
);
  initial begin
    {cyc_o, stb_o, we_o, hung_o} = 4'h0;
    adr_o = 32'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // One cycle, held until ack is sampled; caller enters just after an edge
  task xfer(input logic w, input logic [8:0] idx, input logic [3:0] s,
            input logic [31:0] d, output logic [31:0] q);
    integer n;
    n = 0;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {21'h0, idx, 2'b00};
    sel_o <= s;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1 && n < 64) begin
      @(posedge clk_i);
      n++;
    end
    q = dat_i;
    if (n == 64) hung_o <= 1'b1;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data no longer shows the written value
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // tglm_host_model
`default_nettype wire

// ---- tglm_map.vh ----
// Register map, reset values and timing constants of the tone generator bank
`ifndef TGLM_MAP_VH
`define TGLM_MAP_VH

// Register indexes; the byte address is four times the index
`define TGLM_IDX_TONE_A      9'h191
`define TGLM_IDX_TONE_B      9'h196
`define TGLM_IDX_LOW_LEV     9'h1a0
`define TGLM_IDX_HIGH_LEV    9'h1a1
`define TGLM_IDX_LINK_MODE   9'h1f0
`define TGLM_IDX_CONFIG      9'h1e0
// Word index is taken from these address bits
`define TGLM_ADR_HI          10
`define TGLM_ADR_LO          2

// Configuration mode field
`define TGLM_MODE_W          7
`define TGLM_MODE_STANDBY    7'h00
`define TGLM_MODE_TX_TONES   7'h01

// Connection mode codes
`define TGLM_LM_V22BIS_2400  7'h08
`define TGLM_LM_V22_1200     7'h09
`define TGLM_LM_B212A_1200   7'h0b
`define TGLM_LM_V21_300      7'h10
`define TGLM_LM_B103_300     7'h11
`define TGLM_LM_V23_TX1200   7'h13
`define TGLM_LM_V23_TX75     7'h14
`define TGLM_LM_V29_9600     7'h20
`define TGLM_LM_V29_7200     7'h21
`define TGLM_LM_NONE         7'h00

// Level defaults, 32767 * 10^(dBm/20)
`define TGLM_HIGH_LEV_RST    16'h4027
`define TGLM_LOW_LEV_RST     16'h2d6a
`define TGLM_COEFF_RST       16'h0000

// Timing
`define TGLM_CLK_HZ          125000000
`define TGLM_SAMPLE_HZ       9600
`define TGLM_APPLY_TIME_NS   100000
`define TGLM_CLK_PERIOD_NS   8

// Phase: one full cycle is 2*pi*4096 units, index scale maps it to 64 points
`define TGLM_FULL_CYCLE      18'd25736
`define TGLM_PH_TO_IDX       8'd162
`define TGLM_IDX_SHIFT       16
`define TGLM_LEV_SHIFT       15

`endif

// ---- tglm_tone_bank.v ----
// Tone generator and link mode parameter bank with classic Wishbone slave
//
// How it works
// - Store negotiated link mode after handshake completes
// - Codes 08, 09, 0B for 2400/1200 links
// - Codes 10, 11 for 300 bps links
// - Codes 13, 14 for V.23 directions
// - Codes 20, 21 for V.29 quick connect
// - Reset loads -6 and -9 dBm levels
// - New levels reach the output within 0.1 ms
// - Transmit-tones mode runs two generators together
// - Both generator outputs are summed together
// - Generator A low band, B high band
`timescale 1ns/10ps
`default_nettype none
`include "tglm_map.vh"

module tglm_tone_bank #(
  // Clocks per 9600 Hz sample, shortened in simulation
  parameter integer SAMPLE_DIV = `TGLM_CLK_HZ / `TGLM_SAMPLE_HZ
) (
  input  wire        clk_i,              // 125 MHz clock
  input  wire        rst_i,              // Synchronous reset, active high
  input  wire        wb_cyc_i,           // Wishbone cycle
  input  wire        wb_stb_i,           // Wishbone strobe
  input  wire        wb_we_i,            // Wishbone write enable
  input  wire [31:0] wb_adr_i,           // Wishbone byte address
  input  wire [3:0]  wb_sel_i,           // Wishbone byte selects
  input  wire [31:0] wb_dat_i,           // Wishbone write data
  output wire [31:0] wb_dat_o,           // Wishbone read data
  output wire        wb_ack_o,           // Wishbone acknowledge
  input  wire        handshake_done_i,   // Pulse, handshake finished
  input  wire [6:0]  negotiated_mode_i,  // Code valid with the pulse
  output wire [15:0] tone_sample_o,      // Mixed signed tone output
  output wire        sample_strobe_o     // Pulse each 9600 Hz sample
);

  // Cycles allowed for a level change to reach the output
  localparam integer APPLY_CYC = `TGLM_APPLY_TIME_NS / `TGLM_CLK_PERIOD_NS;

  // Bus registers
  reg        ack_reg;                    // Acknowledge flop
  reg [31:0] dat_reg;                    // Read data flop
  reg [15:0] coeff_a_reg;                // Generator A frequency coefficient
  reg [15:0] coeff_b_reg;                // Generator B frequency coefficient
  reg [15:0] low_lev_reg;                // Low band level
  reg [15:0] high_lev_reg;               // High band level
  reg [6:0]  link_mode_reg;              // Established link mode
  reg [6:0]  config_mode_reg;            // Configuration mode field
  // Generator state
  reg [13:0] div_reg;                    // Sample divider
  reg        strobe_reg;                 // Sample strobe output flop
  reg [17:0] phase_a_reg;                // Phase accumulator A
  reg [17:0] phase_b_reg;                // Phase accumulator B
  reg [15:0] sample_reg;                 // Output sample flop

  // Decode helpers
  wire [8:0] idx     = wb_adr_i[`TGLM_ADR_HI:`TGLM_ADR_LO];  // Word index
  wire       req     = wb_cyc_i & wb_stb_i & ~ack_reg;       // New access
  wire       wr      = req & wb_we_i;                        // Write access
  wire       tx_tone = (config_mode_reg == `TGLM_MODE_TX_TONES);
  wire       tick    = (div_reg == SAMPLE_DIV[13:0] - 14'h0001);

  // Merge byte lanes 0 and 1 into a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old;
    input [3:0]  sel;
    input [31:0] din;
    begin
      lane_merge[7:0]  = sel[0] ? din[7:0]  : old[7:0];
      lane_merge[15:8] = sel[1] ? din[15:8] : old[15:8];
    end
  endfunction

  // True for a connection code the link may report
  function mode_legal;
    input [6:0] m;
    begin
      case (m)
        `TGLM_LM_V22BIS_2400,
        `TGLM_LM_V22_1200,
        `TGLM_LM_B212A_1200:  mode_legal = 1'b1;
        `TGLM_LM_V21_300,
        `TGLM_LM_B103_300:    mode_legal = 1'b1;
        `TGLM_LM_V23_TX1200,
        `TGLM_LM_V23_TX75:    mode_legal = 1'b1;
        `TGLM_LM_V29_9600,
        `TGLM_LM_V29_7200:    mode_legal = 1'b1;
        default:              mode_legal = 1'b0;
      endcase
    end
  endfunction

  // Phase step with wrap; up to three subtractions cover any coefficient
  function [17:0] phase_step;
    input [17:0] ph;
    input [15:0] coeff;
    reg   [17:0] s;
    begin
      s = ph + {2'b00, coeff};
      if (s >= `TGLM_FULL_CYCLE) begin
        s = s - `TGLM_FULL_CYCLE;
      end
      if (s >= `TGLM_FULL_CYCLE) begin
        s = s - `TGLM_FULL_CYCLE;
      end
      if (s >= `TGLM_FULL_CYCLE) begin
        s = s - `TGLM_FULL_CYCLE;
      end
      phase_step = s;
    end
  endfunction

  // Quarter wave sine table, 16 steps per quarter, Q15
  function [15:0] quarter_sin;
    input [4:0] k;
    begin
      case (k)
        5'h00:   quarter_sin = 16'h0000;
        5'h01:   quarter_sin = 16'h0c8c;
        5'h02:   quarter_sin = 16'h18f9;
        5'h03:   quarter_sin = 16'h2528;
        5'h04:   quarter_sin = 16'h30fb;
        5'h05:   quarter_sin = 16'h3c56;
        5'h06:   quarter_sin = 16'h471c;
        5'h07:   quarter_sin = 16'h5133;
        5'h08:   quarter_sin = 16'h5a82;
        5'h09:   quarter_sin = 16'h62f1;
        5'h0a:   quarter_sin = 16'h6a6d;
        5'h0b:   quarter_sin = 16'h70e2;
        5'h0c:   quarter_sin = 16'h7641;
        5'h0d:   quarter_sin = 16'h7a7c;
        5'h0e:   quarter_sin = 16'h7d89;
        5'h0f:   quarter_sin = 16'h7f61;
        5'h10:   quarter_sin = 16'h7fff;
        default: quarter_sin = 16'h0000;
      endcase
    end
  endfunction

  // Signed sine of a phase, 64 points per cycle
  function signed [15:0] phase_sin;
    input [17:0] ph;
    reg   [25:0] prod;
    reg   [5:0]  id;
    reg   [15:0] mag;
    begin
      prod = ph * `TGLM_PH_TO_IDX;
      id   = prod[`TGLM_IDX_SHIFT+5:`TGLM_IDX_SHIFT];
      // Odd quarters read the table backwards
      if (id[4]) begin
        mag = quarter_sin(5'h10 - {1'b0, id[3:0]});
      end else begin
        mag = quarter_sin({1'b0, id[3:0]});
      end
      // Second half of the cycle is negative
      if (id[5]) begin
        phase_sin = -$signed(mag);
      end else begin
        phase_sin = $signed(mag);
      end
    end
  endfunction

  // Scaled tone of one generator, Q15 * level
  function signed [32:0] scale_tone;
    input [17:0] ph;
    input [15:0] lev;
    begin
      scale_tone = phase_sin(ph) * $signed({1'b0, lev});
    end
  endfunction

  // Mixer, combinational; the level enters without any sample delay
  reg signed [33:0] mix_sum;             // Sum of both scaled tones
  reg signed [18:0] mix_q15;             // Sum back in Q15 range
  reg        [15:0] mix_sat;             // Saturated sample
  reg signed [32:0] tone_a_sc;           // Generator A scaled by its level
  reg signed [32:0] tone_b_sc;           // Generator B scaled by its level
  always @* begin
    // A uses low band, B high band
    tone_a_sc = scale_tone(phase_a_reg, low_lev_reg);
    tone_b_sc = scale_tone(phase_b_reg, high_lev_reg);
    // Add both outputs; both signed, so the sum sign-extends
    mix_sum = tone_a_sc + tone_b_sc;
    mix_q15 = mix_sum[`TGLM_LEV_SHIFT+18:`TGLM_LEV_SHIFT];
    // Two full-scale tones can overflow, so clip rather than wrap
    if (mix_q15 > 19'sd32767) begin
      mix_sat = 16'h7fff;
    end else if (mix_q15 < -19'sd32768) begin
      mix_sat = 16'h8000;
    end else begin
      mix_sat = mix_q15[15:0];
    end
  end

  // Wishbone slave: one wait state, ack drops the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req && !wb_we_i) begin
        case (idx)
          `TGLM_IDX_TONE_A:    dat_reg <= {16'h0000, coeff_a_reg};
          `TGLM_IDX_TONE_B:    dat_reg <= {16'h0000, coeff_b_reg};
          `TGLM_IDX_LOW_LEV:   dat_reg <= {16'h0000, low_lev_reg};
          `TGLM_IDX_HIGH_LEV:  dat_reg <= {16'h0000, high_lev_reg};
          `TGLM_IDX_LINK_MODE: dat_reg <= {25'h0000000, link_mode_reg};
          `TGLM_IDX_CONFIG:    dat_reg <= {25'h0000000, config_mode_reg};
          // Unmapped reads answer zero
          default:             dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writable parameter registers; unmapped writes are dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      coeff_a_reg     <= `TGLM_COEFF_RST;
      coeff_b_reg     <= `TGLM_COEFF_RST;
      low_lev_reg     <= `TGLM_LOW_LEV_RST;
      high_lev_reg    <= `TGLM_HIGH_LEV_RST;
      config_mode_reg <= `TGLM_MODE_STANDBY;
    end else if (wr) begin
      case (idx)
        `TGLM_IDX_TONE_A:   coeff_a_reg  <= lane_merge(coeff_a_reg, wb_sel_i, wb_dat_i);
        `TGLM_IDX_TONE_B:   coeff_b_reg  <= lane_merge(coeff_b_reg, wb_sel_i, wb_dat_i);
        `TGLM_IDX_LOW_LEV:  low_lev_reg  <= lane_merge(low_lev_reg, wb_sel_i, wb_dat_i);
        `TGLM_IDX_HIGH_LEV: high_lev_reg <= lane_merge(high_lev_reg, wb_sel_i, wb_dat_i);
        `TGLM_IDX_CONFIG: begin
          if (wb_sel_i[0]) begin
            config_mode_reg <= wb_dat_i[`TGLM_MODE_W-1:0];
          end
        end
        // Read-only link mode and holes ignore writes
        default: ;
      endcase
    end
  end

  // Link mode report, written only by the handshake logic
  always @(posedge clk_i) begin
    if (rst_i) begin
      link_mode_reg <= `TGLM_LM_NONE;
    end else if (handshake_done_i && mode_legal(negotiated_mode_i)) begin
      link_mode_reg <= negotiated_mode_i;
    end
  end

  // Sample divider, 9600 Hz enable pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_reg    <= 14'h0000;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= tick;
      if (tick) begin
        div_reg <= 14'h0000;
      end else begin
        div_reg <= div_reg + 14'h0001;
      end
    end
  end

  // Phase accumulators, held at zero outside transmit-tones mode
  always @(posedge clk_i) begin
    if (rst_i || !tx_tone) begin
      phase_a_reg <= 18'h00000;
      phase_b_reg <= 18'h00000;
    end else if (tick) begin
      phase_a_reg <= phase_step(phase_a_reg, coeff_a_reg);
      phase_b_reg <= phase_step(phase_b_reg, coeff_b_reg);
    end
  end

  // Output sample flop, refreshed every clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      sample_reg <= 16'h0000;
    end else if (tx_tone) begin
      sample_reg <= mix_sat;
    end else begin
      sample_reg <= 16'h0000;
    end
  end

  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = dat_reg;
  assign tone_sample_o   = sample_reg;
  assign sample_strobe_o = strobe_reg;

endmodule // tglm_tone_bank
`default_nettype wire

// ---- tglm_tone_bank_tb.sv ----
// Self-checking bench for the tone bank
`timescale 1ns/10ps
`default_nettype none
`include "tglm_map.vh"
module tglm_tone_bank_tb;
  localparam integer DIV = 16;  // Short sample period keeps the run brief
  logic        clk_i = 1'b0, rst_i = 1'b1, hs = 1'b0;
  logic [6:0]  code = 7'h00;
  logic [31:0] q;
  logic [15:0] v1, v2;
  wire logic        cyc, stb, we, ack, hung, strobe;
  wire logic [31:0] adr, wdat, rdat;
  wire logic [3:0]  sel;
  wire logic [15:0] tone;
  integer      err_total = 0, checks_done = 0, i;
  logic [6:0]  codes [9] = '{`TGLM_LM_V22BIS_2400, `TGLM_LM_V22_1200, `TGLM_LM_B212A_1200,
    `TGLM_LM_V21_300, `TGLM_LM_B103_300, `TGLM_LM_V23_TX1200, `TGLM_LM_V23_TX75,
    `TGLM_LM_V29_9600, `TGLM_LM_V29_7200};
  tglm_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hung_o(hung));
  tglm_tone_bank #(.SAMPLE_DIV(DIV)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .handshake_done_i(hs), .negotiated_mode_i(code),
    .tone_sample_o(tone), .sample_strobe_o(strobe));
  initial forever #4 clk_i = ~clk_i;
  task test_done;
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [8:0] idx, input logic [15:0] d, input logic [3:0] s = 4'h3);
    host.xfer(1'b1, idx, s, {16'h0, d}, q);
  endtask
  task rdc(input string what, input logic [8:0] idx, input logic [31:0] exp);
    host.xfer(1'b0, idx, 4'hf, 32'h0, q);
    chk(what, exp, q);
  endtask
  // Bounded wait for the next sample strobe
  task wait_strobe;
    for (i = 0; i < 4 * DIV && strobe !== 1'b1; i++) @(posedge clk_i);
    if (strobe !== 1'b1) chk("strobe", 1, 0);
    @(posedge clk_i);
  endtask
  // OR of the tone over four samples, so any nonzero output shows
  task gather;
    v1 = 16'h0;
    repeat (4 * DIV) begin
      @(posedge clk_i);
      v1 = v1 | tone;
    end
  endtask
  // Tone must stay zero for several samples
  task quiet(input string what);
    gather;
    chk(what, 0, {16'h0, v1});
  endtask
  task t_reset_values;
    rdc("low level", `TGLM_IDX_LOW_LEV, {16'h0, `TGLM_LOW_LEV_RST});
    rdc("high level", `TGLM_IDX_HIGH_LEV, {16'h0, `TGLM_HIGH_LEV_RST});
    rdc("link mode", `TGLM_IDX_LINK_MODE, 0);
  endtask
  task t_bus_edges;
    wr(`TGLM_IDX_LINK_MODE, 16'h0055);
    rdc("ro link mode", `TGLM_IDX_LINK_MODE, 0);
    rdc("unmapped", 9'h000, 0);
    wr(`TGLM_IDX_TONE_A, 16'habcd, 4'h1);
    rdc("lane write", `TGLM_IDX_TONE_A, 32'h00cd);
  endtask
  task t_link_codes;
    for (int k = 0; k < 10; k++) begin
      code <= (k == 9) ? 7'h05 : codes[k];
      hs   <= 1'b1;
      @(posedge clk_i);
      hs   <= 1'b0;
      @(posedge clk_i);
      rdc("link code", `TGLM_IDX_LINK_MODE, {25'h0, codes[k == 9 ? 8 : k]});
    end
  endtask
  // Mixed output with given levels; phases restart when the mode is entered
  task run_mix(input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] cb);
    wr(`TGLM_IDX_CONFIG, `TGLM_MODE_STANDBY);
    wr(`TGLM_IDX_LOW_LEV, lo);
    wr(`TGLM_IDX_HIGH_LEV, hi);
    wr(`TGLM_IDX_TONE_B, cb);
    wait_strobe;
    wr(`TGLM_IDX_CONFIG, `TGLM_MODE_TX_TONES);
    repeat (3) wait_strobe;
    repeat (3) @(posedge clk_i);
    v2 = tone;
  endtask
  task t_tones;
    wr(`TGLM_IDX_TONE_A, 16'h0c91);
    quiet("standby tone");
    run_mix(16'h0000, 16'h7fff, 16'h0000);
    quiet("gen a muted");
    wr(`TGLM_IDX_LOW_LEV, 16'h7fff);
    // One sample may sit on a zero crossing, so watch a span
    gather;
    chk("gen a live", 1, {31'h0, v1 != 16'h0});
    wr(`TGLM_IDX_LOW_LEV, 16'h0000);
    repeat (2) @(posedge clk_i);
    quiet("level applied");
    run_mix(16'h2000, 16'h2000, 16'h0c91);
    v1 = v2;
    run_mix(16'h4000, 16'h0000, 16'h0000);
    chk("sum of tones", {16'h0, v2}, {16'h0, v1});
    chk("sum live", 1, {31'h0, v1 != 16'h0});
  endtask
  always @(posedge hung) begin
    err_total++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_values;
    t_bus_edges;
    t_link_codes;
    t_tones;
    test_done;
  end
endmodule // tglm_tone_bank_tb
bind tglm_tone_bank tglm_bank_sva #(.SAMPLE_DIV(SAMPLE_DIV)) u_sva (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .handshake_done_i(handshake_done_i), .negotiated_mode_i(negotiated_mode_i),
  .tone_sample_o(tone_sample_o), .sample_strobe_o(sample_strobe_o));
`default_nettype wire
